// >>> rtl/secure_debug_access_lock.sv
// module: debug lock, debug path isolation and revoked key read guard
`timescale 1ns/10ps
module secure_debug_access_lock
   import debug_lock_pkg::*;
#(
   parameter int KW = KEY_W                    // key word width
)
(
   input  wire logic          mclk,            // system clock, 100 MHz
   input  wire logic          sys_rst,         // hardware reset, sync, high
   input  wire logic          sw_rst,          // software reset, sync, high
   input  wire logic          lock_wr,         // write strobe to lock bit
   input  wire logic          lock_wdata,      // data for lock bit
   input  wire logic          enable_wr,       // write strobe to enable bit
   input  wire logic          enable_wdata,    // data for enable bit
   input  wire logic          probe_swclk,     // probe clock pin
   input  wire logic          probe_swdio_in,  // probe data pin input
   output logic               probe_swdio_out, // data toward probe pin
   output logic               probe_swdio_oe,  // drive enable toward probe
   output logic               core_swclk,      // clock to debug controller
   output logic               core_swdio_in,   // data to debug controller
   input  wire logic          core_swdio_out,  // data from debug controller
   input  wire logic          core_swdio_oe,   // drive enable from controller
   input  wire logic          key_rd,          // read of key storage word
   input  wire logic [KW-1:0] key_rdata_raw,   // word from key storage
   output logic [KW-1:0]      key_rdata,       // returned read data
   output logic               key_err,         // bus error answer, one cycle
   output logic               debug_locked,    // lock bit state
   output logic               debugger_enable  // enable bit state
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic lock_q;          // sticky debug lock
   logic en_q;            // debugger enable
   localparam int NPIN    = 2;   // number of synchronised probe pins
   localparam int PIN_CLK = 0;   // slot of the probe clock
   localparam int PIN_DIO = 1;   // slot of the probe data line
   logic [NPIN-1:0] pin_raw;     // probe pins as they arrive
   logic [NPIN-1:0] pin_s1_q;    // first stage, may be metastable
   logic [NPIN-1:0] pin_s2_q;    // second stage, safe to use
   logic conn;            // debug path connected
   logic key_revoked;     // stored word carries the revoked pattern

   // ----------------------------------------
   // lock and enable bits
   // ----------------------------------------
   // sticky lock: only sys_rst clears; sw_rst deliberately ignored
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         lock_q <= DBG_LOCK_RST;
      else if (lock_wr && lock_wdata)
         lock_q <= 1'b1;                      // zero writes do nothing
   end

   // enable bit: both resets return it to disabled
   always_ff @(posedge mclk)
   begin
      if (sys_rst || sw_rst)
         en_q <= DBG_EN_RST;
      else if (enable_wr)
         en_q <= enable_wdata;
   end

   // ----------------------------------------
   // probe pin synchroniser
   // ----------------------------------------
   // pins are asynchronous: two flops before any use; only stage two is read
   assign pin_raw[PIN_CLK] = probe_swclk;
   assign pin_raw[PIN_DIO] = probe_swdio_in;

   // one identical two-stage chain per pin
   for (genvar g = 0; g < NPIN; g++)
   begin : g_sync
      always_ff @(posedge mclk)
      begin
         if (sys_rst)
         begin
            pin_s1_q[g] <= 1'b0;          // idle low, as the probe parks its clock
            pin_s2_q[g] <= 1'b0;
         end
         else
         begin
            pin_s1_q[g] <= pin_raw[g];    // capture, may go metastable
            pin_s2_q[g] <= pin_s1_q[g];   // settled copy for the logic
         end
      end
   end

   // ----------------------------------------
   // path gate
   // ----------------------------------------
   // lock overrides enable, so a late enable write cannot reopen the path
   assign conn = en_q && !lock_q;

   // ----------------------------------------
   // isolation: gated flops keep outputs registered
   // ----------------------------------------
   // core side: a closed path shows the controller a quiet, parked line
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         core_swclk    <= 1'b0;                     // clock parked low
         core_swdio_in <= 1'b0;
      end
      else
      begin
         core_swclk    <= conn & pin_s2_q[PIN_CLK];
         core_swdio_in <= conn & pin_s2_q[PIN_DIO];
      end
   end

   // probe side: the pin is only driven while the path is open
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         probe_swdio_out <= 1'b0;                   // released after reset
         probe_swdio_oe  <= 1'b0;
      end
      else
      begin
         probe_swdio_out <= conn & core_swdio_out;
         probe_swdio_oe  <= conn & core_swdio_oe;
      end
   end

   // ----------------------------------------
   // revoked key guard
   // ----------------------------------------
   // one compare shared by the error and the data paths
   assign key_revoked = (key_rdata_raw == KEY_REVOKED[KW-1:0]);

   // revoked key read: error, data withheld as zero
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         key_err   <= 1'b0;                   // no answer pending
         key_rdata <= '0;
      end
      else
      begin
         key_err   <= key_rd && key_revoked;  // one-cycle error pulse
         key_rdata <= (key_rd && !key_revoked) ? key_rdata_raw : '0;
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   assign debug_locked    = lock_q;
   assign debugger_enable = en_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // a set lock stays set; the reset edge itself disables the check
   a_lock_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_q |=> lock_q)
      else $error("lock cleared without hw reset");
   // a one written to the lock sets it on the next edge
   a_lock_set: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_wr && lock_wdata |=> lock_q)
      else $error("lock not set");
   // a zero written to a clear lock leaves it clear
   a_lock_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_wr && !lock_wdata && !lock_q |=> !lock_q)
      else $error("zero write set the lock");
   // software reset must not touch the lock
   a_lock_swrst: assert property (@(posedge mclk) disable iff (sys_rst)
      sw_rst && lock_q |=> lock_q)
      else $error("sw reset cleared lock");
   // hardware reset always clears the lock
   a_lock_hwrst: assert property (@(posedge mclk)
      sys_rst |=> !lock_q)
      else $error("lock kept through hw reset");
   // either reset leaves the debugger disabled
   a_en_reset: assert property (@(posedge mclk)
      sys_rst || sw_rst |=> !en_q)
      else $error("enable not zero after reset");
   // an enable write outside resets takes the written value
   a_en_write: assert property (@(posedge mclk) disable iff (sys_rst)
      enable_wr && !sw_rst |=> en_q == $past(enable_wdata))
      else $error("enable write lost");
   // while locked, nothing from the probe reaches the core
   a_core_iso: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_q ##1 lock_q |-> !core_swclk && !core_swdio_in)
      else $error("probe reached core while locked");
   // while locked, the core cannot drive the probe pin
   a_probe_lock: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_q |=> !probe_swdio_oe && !probe_swdio_out)
      else $error("core drove probe while locked");
   // a disabled path never drives the probe pin
   a_probe_iso: assert property (@(posedge mclk) disable iff (sys_rst)
      !en_q |=> !probe_swdio_oe)
      else $error("drive while disabled");
   // an open path hands the synchronised clock straight on
   a_path_pass: assert property (@(posedge mclk) disable iff (sys_rst)
      conn |=> core_swclk == $past(pin_s2_q[PIN_CLK]))
      else $error("path not passing");
   // a revoked word answers with an error and no data
   a_key_err: assert property (@(posedge mclk) disable iff (sys_rst)
      key_rd && key_rdata_raw == KEY_REVOKED[KW-1:0] |=> key_err && key_rdata == '0)
      else $error("revoked key read without error");
   // a live word comes back unchanged and without an error
   a_key_pass: assert property (@(posedge mclk) disable iff (sys_rst)
      key_rd && key_rdata_raw != KEY_REVOKED[KW-1:0]
      |=> !key_err && key_rdata == $past(key_rdata_raw))
      else $error("live key read altered");
   // with no read the answer lines rest at zero
   a_key_idle: assert property (@(posedge mclk) disable iff (sys_rst)
      !key_rd |=> !key_err && key_rdata == '0)
      else $error("key answer without a read");

   // ----------------------------------------
   // cover properties
   // ----------------------------------------
   c_lock:        cover property (@(posedge mclk) lock_wr && lock_wdata ##1 lock_q);
   c_conn:        cover property (@(posedge mclk) conn ##1 core_swclk);
   c_err:         cover property (@(posedge mclk) key_err);
   c_swrst_keep:  cover property (@(posedge mclk) sw_rst && lock_q ##1 lock_q && !en_q);
   c_hwrst_clear: cover property (@(posedge mclk) lock_q ##1 sys_rst ##1 !lock_q);
endmodule // secure_debug_access_lock

// >>> rtl/debug_lock_pkg.sv
// package: constants for the secure debug access lock
package debug_lock_pkg;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic DBG_EN_RST   = 1'h0;   // debugger enable after reset
   localparam logic DBG_LOCK_RST = 1'h0;   // lock after hardware reset
   // ----------------------------------------
   // key space and identifier
   // ----------------------------------------
   localparam int   KEY_W        = 32;     // width of a key storage word
   localparam int   UID_W        = 64;     // width of unique identifier
   localparam logic [31:0] KEY_REVOKED = 32'hFFFF_FFFF; // revoked key pattern
endpackage

// >>> bench/swd_probe_model.sv
// bench: external debug probe driving the swd pins
`timescale 1ns/10ps
module swd_probe_model
(
   input  wire logic mclk,    // bench clock
   input  wire logic frame,   // probe is in a frame
   input  wire logic clk_lvl, // clock level inside a frame
   input  wire logic dat,     // data bit inside a frame
   output logic      swclk,   // probe clock pin
   output logic      swdio    // probe data pin
);
   logic last_q = 1'b0;       // last bit driven in a frame
   // remember the last bit so a released line can show its inverse
   always @(posedge mclk)
      if (frame) last_q <= dat;
   // clock stands still between frames; stale data never lingers on the pin
   // the probe talks only on this one configured pin pair
   assign swclk = frame ? clk_lvl : 1'b0;
   assign swdio = frame ? dat : ~last_q;
endmodule // swd_probe_model

// >>> bench/secure_debug_access_lock_tb_top.sv
// bench: self-checking testbench for the secure debug access lock
`timescale 1ns/10ps
module secure_debug_access_lock_tb_top;
   import debug_lock_pkg::*;
   logic mclk=0, sys_rst=1, sw_rst=0, lock_wr=0, lock_wdata=0, enable_wr=0, enable_wdata=0;
   logic frame=0, clk_lvl=0, dat=0, core_swdio_out=0, core_swdio_oe=0, key_rd=0, rd_d=0;
   logic probe_swclk, probe_swdio_in, probe_swdio_out, probe_swdio_oe, core_swclk;
   logic core_swdio_in, key_err, debug_locked, debugger_enable;
   logic [KEY_W-1:0] key_rdata_raw=0, key_rdata;
   logic [KEY_W:0]   exp_q[$];  // expected {error, data} of each key read
   logic [KEY_W-1:0] uid_hi, uid_lo;  // two header words of the identifier
   logic [UID_W-1:0] uid_seen = '0;   // read data seen, oldest word high
   int fail_count=0, n_tests=0, seed=32'h1b627c8f;
   secure_debug_access_lock dut (.mclk, .sys_rst, .sw_rst, .lock_wr, .lock_wdata, .enable_wr,
      .enable_wdata, .probe_swclk, .probe_swdio_in, .probe_swdio_out, .probe_swdio_oe,
      .core_swclk, .core_swdio_in, .core_swdio_out, .core_swdio_oe, .key_rd, .key_rdata_raw,
      .key_rdata, .key_err, .debug_locked, .debugger_enable);
   swd_probe_model probe (.mclk, .frame, .clk_lvl, .dat, .swclk(probe_swclk),
      .swdio(probe_swdio_in));
   task chk(input logic [UID_W-1:0] got, input logic [UID_W-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("tests=%0d fails=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one write strobe: l picks the lock bit, else the enable bit
   task wr(input logic l, input logic d);
      @(negedge mclk);
      {lock_wr, enable_wr, lock_wdata, enable_wdata} = {l, !l, d, d};
      @(negedge mclk);
      {lock_wr, enable_wr} = 2'b00;
   endtask
   // key read; a revoked word must answer with an error and no data
   task rd(input logic [KEY_W-1:0] w);
      @(negedge mclk);
      {key_rd, key_rdata_raw} = {1'b1, w};
      exp_q.push_back((&w) ? {1'b1, {KEY_W{1'b0}}} : {1'b0, w});
      @(negedge mclk);
      key_rd = 1'b0;
   endtask
   initial forever #5 mclk = ~mclk;
   initial
   begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      print_verdict;
   end
   // watcher: answer lands one cycle after the read is taken
   always @(posedge mclk) rd_d <= key_rd;
   always @(negedge mclk)
      if (rd_d)
      begin
         uid_seen = {uid_seen[KEY_W-1:0], key_rdata};
         if (exp_q.size() > 0)
            chk({key_err, key_rdata}, exp_q.pop_front());
         else
            chk({key_err, key_rdata}, {UID_W{1'b1}}); // stray answer never matches
      end
   initial
   begin
      repeat (6) @(negedge mclk);
      sys_rst = 1'b0;
      chk({debug_locked, debugger_enable}, 2'b00);
      {frame, clk_lvl, core_swdio_oe, dat, core_swdio_out} = {3'b111, 2'($random(seed))};
      wr(1'b0, 1'b1);
      repeat (4) @(negedge mclk);
      chk({core_swclk, core_swdio_in, probe_swdio_oe, probe_swdio_out},
          {1'b1, dat, 1'b1, core_swdio_out});
      wr(1'b1, 1'b0);
      chk(debug_locked, 1'b0);
      {dat, core_swdio_out} = 2'b11;  // ones on both lines, so a leak shows
      wr(1'b1, 1'b1);
      repeat (3) @(negedge mclk);
      chk({debug_locked, core_swclk, core_swdio_in, probe_swdio_oe, probe_swdio_out},
          5'h10);
      wr(1'b1, 1'b0);
      chk(debug_locked, 1'b1);
      sw_rst = 1'b1; // software reset after a good image check
      @(negedge mclk);
      sw_rst = 1'b0;
      chk({debug_locked, debugger_enable}, 2'b10);
      wr(1'b1, 1'b1); // boot firmware sets the lock again
      chk(debug_locked, 1'b1);
      sys_rst = 1'b1;
      @(negedge mclk);
      sys_rst = 1'b0;
      chk({debug_locked, debugger_enable}, 2'b00);
      repeat (3) @(negedge mclk);
      chk({core_swclk, core_swdio_in, probe_swdio_oe, probe_swdio_out}, 4'h0);
      wr(1'b1, 1'b1); // set again after hardware reset too
      chk(debug_locked, 1'b1);
      rd(KEY_REVOKED);
      rd($random(seed));
      rd(32'hFFFF_FFFE);
      rd(KEY_REVOKED);
      uid_hi = $random(seed);
      uid_lo = $random(seed);
      rd(uid_hi);
      rd(uid_lo);
      repeat (2) @(negedge mclk);
      chk(exp_q.size(), 0);
      chk(uid_seen, {uid_hi, uid_lo});
      print_verdict;
   end
endmodule // secure_debug_access_lock_tb_top
